/* logic/rmi_defs.svh */
// rmi_defs.svh: offsets, field positions, reset values and characters of the message interface
`ifndef RMI_DEFS_SVH
`define RMI_DEFS_SVH
// register byte offsets
`define RMI_OFF_CTRL 8'h00
`define RMI_OFF_SERCFG 8'h04
`define RMI_OFF_STATUS 8'h08
// control register field positions
`define RMI_CTRL_SERIAL_BIT 0
`define RMI_CTRL_ACKSUP_BIT 1
`define RMI_CTRL_TERM_LSB 2
`define RMI_CTRL_ADDR_LSB 8
// reset values
`define RMI_RST_ACK_SUP 1'b1
`define RMI_RST_TERM_SEL 2'h0
`define RMI_RST_GPIB_ADDR 5'h01
`define RMI_RST_SERCFG 21'h03_0001
// characters
`define RMI_CH_DC1 8'h11
`define RMI_CH_DC3 8'h13
`define RMI_CH_SP 8'h20
`define RMI_CH_HASH 8'h23
`define RMI_CH_COMMA 8'h2C
`define RMI_CH_SEMI 8'h3B
`define RMI_CH_QM 8'h3F
`define RMI_CH_AT 8'h40
`define RMI_CH_HEXH 8'h48
`define RMI_CH_LF 8'h0A
`define RMI_CH_CR 8'h0D
// recognised headers and answer words
`define RMI_HDR_ACKSUP 24'h53_494C
`define RMI_HDR_TERMSEL 24'h54_524D
`define RMI_HDR_STATUS 24'h44_5352
`define RMI_ACK_OK 40'h00_0000_4B4F
`define RMI_ACK_ERROR 40'h52_4F52_5245
`endif

/* logic/rmi_msg_if.sv */
// rmi_msg_if: message parser, settings and response sender with apb registers
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "rmi_defs.svh"
module rmi_msg_if
(
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic rx_valid_in,
   input wire rmi_pkg::rmi_rx_type rx_in,
   output logic rx_ready_out,
   output logic tx_valid_out,
   output rmi_pkg::rmi_tx_type tx_out,
   input wire logic tx_ready_in,
   input wire logic [7:0] dev_status_in,
   output logic holdoff_out,
   output logic serial_sel_out,
   output logic [4:0] gpib_addr_out,
   output rmi_pkg::rmi_sercfg_type sercfg_out
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   rmi_pkg::rmi_state_type state_ff; // sequence
   rmi_pkg::rmi_ctrl_type ctrl_ff; // control settings
   rmi_pkg::rmi_sercfg_type sercfg_ff; // line settings
   rmi_pkg::rmi_tx_type tx_ff; // outgoing byte
   logic tx_valid_ff;
   logic paused_ff; // far end asked us to pause
   logic xoff_sent_ff; // we asked far end to pause
   logic holdoff_ff;
   logic [23:0] hdr_ff; // last three header letters
   logic [2:0] hlen_ff; // header length, saturating
   logic in_data_ff, query_ff, hash_ff, hex_ff, got_ff, bad_ff;
   logic [15:0] val_ff; // first data item
   logic [3:0] items_ff; // commas seen
   logic [1:0] at_ff; // at-signs seen
   logic [63:0] resp_ff; // response bytes, first in low byte
   logic [2:0] rlen_ff, idx_ff;
   logic last_err_ff, last_q_ff;
   logic [15:0] msg_cnt_ff;
   logic [31:0] prdata_ff;

   // ----------------------------------------
   // digit decode
   // ----------------------------------------
   // returns {valid, value} for a decimal or hexadecimal digit
   function automatic logic [4:0] dig_val(input logic [7:0] c, input logic hex);
      logic [4:0] r;
      r = 5'h00;
      if (c >= 8'h30 && c <= 8'h39)
         r = {1'b1, c[3:0]};
      else if (hex && c >= 8'h41 && c <= 8'h46)
         r = {1'b1, 4'(c[3:0] + 4'h9)};
      return r;
   endfunction : dig_val

   // ----------------------------------------
   // receive decode
   // ----------------------------------------
   wire serial = ctrl_ff.serial_sel;
   wire [7:0] ch = rx_in.data;
   // upper-case letters so lower-case headers match
   wire [7:0] cu = (ch >= 8'h61 && ch <= 8'h7A) ? 8'(ch - 8'h20) : ch;
   wire take = rx_valid_in & rx_ready_out;
   wire is_dc1 = serial & (ch == `RMI_CH_DC1);
   wire is_dc3 = serial & (ch == `RMI_CH_DC3);
   wire addr_ok = serial | (rx_in.addr == ctrl_ff.gpib_addr);
   wire eoi_v = ~serial & rx_in.eoi;
   wire chr = take & ~is_dc1 & ~is_dc3 & addr_ok;
   wire is_lf = (ch == `RMI_CH_LF);
   wire is_cr = (ch == `RMI_CH_CR);
   wire is_at = (ch == `RMI_CH_AT);
   wire is_semi = (ch == `RMI_CH_SEMI);
   wire sep = is_lf | is_cr | is_semi;
   wire msg_end = chr & (is_lf | is_semi | eoi_v);
   wire eoi_only = eoi_v & ~is_lf & ~is_cr;
   wire [1:0] at_new = (is_at && at_ff != 2'h3) ? 2'(at_ff + 2'h1) : at_ff;
   wire hold_hit = msg_end && (at_new >= (eoi_only ? 2'h2 : 2'h1));
   wire [4:0] dv = dig_val(cu, hex_ff);
   wire [15:0] val_mul = hex_ff ? {val_ff[11:0], 4'h0} : 16'(val_ff * 16'h000A);
   wire [15:0] nxt_val = 16'(val_mul + {12'h000, dv[3:0]});

   // ----------------------------------------
   // execution decode
   // ----------------------------------------
   wire h3 = (hlen_ff == 3'h3);
   wire is_sil = h3 & (hdr_ff == `RMI_HDR_ACKSUP);
   wire is_tsel = h3 & (hdr_ff == `RMI_HDR_TERMSEL);
   wire is_dsr = h3 & (hdr_ff == `RMI_HDR_STATUS);
   wire set_bad = is_dsr | ~got_ff | (items_ff != 4'h0) |
                  (is_sil & (val_ff > 16'h0001)) | (is_tsel & (val_ff > 16'h0003));
   // unknown header or bad data rejects the message
   wire err = ~(is_sil | is_tsel | is_dsr) | bad_ff | (~query_ff & set_bad);
   wire exec = (state_ff == rmi_pkg::ST_EXEC);
   wire apply_set = exec & ~err & ~query_ff;
   wire ack_en = serial & ~ctrl_ff.ack_sup;
   // query value: a setting or the device status
   wire [7:0] qv = is_sil ? {7'h00, ctrl_ff.ack_sup} :
                   is_tsel ? {6'h00, ctrl_ff.term_sel} : dev_status_in;
   wire [7:0] d_h = 8'(qv / 8'h64);
   wire [7:0] d_t = 8'((qv / 8'h0A) % 8'h0A);
   wire [7:0] d_o = 8'(qv % 8'h0A);
   wire [39:0] dig_vec = (qv >= 8'h64) ?
                         {16'h0000, 8'(8'h30 + d_o), 8'(8'h30 + d_t), 8'(8'h30 + d_h)} :
                         (qv >= 8'h0A) ? {24'h00_0000, 8'(8'h30 + d_o), 8'(8'h30 + d_t)} :
                         {32'h0000_0000, 8'(8'h30 + d_o)};
   wire [2:0] dig_len = (qv >= 8'h64) ? 3'h3 : (qv >= 8'h0A) ? 3'h2 : 3'h1;
   wire q_ok = query_ff & ~err;
   wire [39:0] body_vec = q_ok ? dig_vec : ~ack_en ? 40'h00_0000_0000 :
                          err ? `RMI_ACK_ERROR : `RMI_ACK_OK;
   wire [2:0] body_len = q_ok ? dig_len : ~ack_en ? 3'h0 : err ? 3'h5 : 3'h2;
   // response terminator: 0 cr lf, 1 lf, 2 none, 3 cr
   wire [1:0] ts = ctrl_ff.term_sel;
   wire [15:0] term_vec = (ts == 2'h0) ? {`RMI_CH_LF, `RMI_CH_CR} :
                          (ts == 2'h1) ? {8'h00, `RMI_CH_LF} :
                          (ts == 2'h3) ? {8'h00, `RMI_CH_CR} : 16'h0000;
   wire [2:0] term_len = (ts == 2'h0) ? 3'h2 : (ts == 2'h2) ? 3'h0 : 3'h1;
   wire [63:0] resp_vec = {24'h00_0000, body_vec} |
                          ({48'h0000_0000_0000, term_vec} << {body_len, 3'b000});
   wire [2:0] resp_len = (body_len == 3'h0) ? 3'h0 : 3'(body_len + term_len);

   // ----------------------------------------
   // transmit path
   // ----------------------------------------
   wire tx_load = ~tx_valid_ff | tx_ready_in;
   wire want_off = (state_ff != rmi_pkg::ST_PARSE);
   wire flow_pend = serial & (want_off != xoff_sent_ff);
   wire send = (state_ff == rmi_pkg::ST_SEND);
   wire issue = send & ~(serial & paused_ff) & ~flow_pend & tx_load;
   wire last_b = (idx_ff == 3'(rlen_ff - 3'h1));
   wire [7:0] cur_b = resp_ff[{idx_ff, 3'b000} +: 8];

   assign rx_ready_out = (state_ff == rmi_pkg::ST_PARSE);
   assign tx_valid_out = tx_valid_ff;
   assign tx_out = tx_ff;
   assign holdoff_out = holdoff_ff;
   assign serial_sel_out = ctrl_ff.serial_sel;
   assign gpib_addr_out = ctrl_ff.gpib_addr;
   assign sercfg_out = sercfg_ff;

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   // parse until a terminator, execute one cycle, then send any answer
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         state_ff <= rmi_pkg::ST_PARSE;
      else
         case (state_ff)
            rmi_pkg::ST_PARSE: if (msg_end) state_ff <= rmi_pkg::ST_EXEC;
            rmi_pkg::ST_EXEC: state_ff <= (resp_len != 3'h0) ? rmi_pkg::ST_SEND :
                                          rmi_pkg::ST_PARSE;
            rmi_pkg::ST_SEND: if (issue && last_b) state_ff <= rmi_pkg::ST_PARSE;
            default: state_ff <= rmi_pkg::ST_PARSE;
         endcase
   end

   // ----------------------------------------
   // message parser
   // ----------------------------------------
   // fields collect while parsing and clear once the message is executed
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         {hdr_ff, hlen_ff, in_data_ff, query_ff, hash_ff, hex_ff} <= '0;
         {got_ff, bad_ff, val_ff, items_ff, at_ff} <= '0;
      end
      else if (exec)
      begin
         {hdr_ff, hlen_ff, in_data_ff, query_ff, hash_ff, hex_ff} <= '0;
         {got_ff, bad_ff, val_ff, items_ff, at_ff} <= '0;
      end
      else if (chr)
      begin
         at_ff <= at_new;
         if (!in_data_ff)
         begin
            if (ch == `RMI_CH_SP)
               in_data_ff <= 1'b1;
            else if (ch == `RMI_CH_QM)
               query_ff <= 1'b1;
            else if (!is_at && !sep)
            begin
               hdr_ff <= {hdr_ff[15:0], cu};
               if (hlen_ff != 3'h7) hlen_ff <= 3'(hlen_ff + 3'h1);
            end
         end
         else if (ch == `RMI_CH_COMMA)
            items_ff <= 4'(items_ff + 4'h1);
         else if (ch == `RMI_CH_HASH)
            hash_ff <= 1'b1;
         else if (hash_ff && !hex_ff && cu == `RMI_CH_HEXH)
            hex_ff <= 1'b1;
         else if (dv[4])
         begin
            if (items_ff == 4'h0) val_ff <= nxt_val;
            got_ff <= 1'b1;
         end
         else if (!is_at && !sep && ch != `RMI_CH_SP)
            bad_ff <= 1'b1;
      end
   end

   // ----------------------------------------
   // settings, flow and hold-off
   // ----------------------------------------
   wire wr = psel_in & penable_in & pwrite_in;
   wire wr_ctrl = wr & (paddr_in == `RMI_OFF_CTRL);
   wire wr_ser = wr & (paddr_in == `RMI_OFF_SERCFG);
   // software write wins over a command in the same cycle
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ctrl_ff <= '{gpib_addr: `RMI_RST_GPIB_ADDR, term_sel: `RMI_RST_TERM_SEL,
                      ack_sup: `RMI_RST_ACK_SUP, serial_sel: 1'b0};
         sercfg_ff <= `RMI_RST_SERCFG;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_ff <= '{gpib_addr: pwdata_in[`RMI_CTRL_ADDR_LSB +: 5],
                         term_sel: pwdata_in[`RMI_CTRL_TERM_LSB +: 2],
                         ack_sup: pwdata_in[`RMI_CTRL_ACKSUP_BIT],
                         serial_sel: pwdata_in[`RMI_CTRL_SERIAL_BIT]};
         else if (apply_set && is_sil)
            ctrl_ff.ack_sup <= val_ff[0];
         else if (apply_set && is_tsel)
            ctrl_ff.term_sel <= val_ff[1:0];
         if (wr_ser)
            sercfg_ff <= pwdata_in[20:0];
      end
   end

   // pause flag, hold-off and message bookkeeping
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         {paused_ff, holdoff_ff, last_err_ff, last_q_ff} <= '0;
         msg_cnt_ff <= 16'h0000;
      end
      else
      begin
         if (take && is_dc3)
            paused_ff <= 1'b1;
         else if (take && is_dc1)
            paused_ff <= 1'b0;
         if (hold_hit)
            holdoff_ff <= 1'b1;
         else if (state_ff != rmi_pkg::ST_PARSE && resp_len == 3'h0 && exec)
            holdoff_ff <= 1'b0;
         else if (issue && last_b)
            holdoff_ff <= 1'b0;
         if (exec)
         begin
            last_err_ff <= err;
            last_q_ff <= query_ff;
            msg_cnt_ff <= 16'(msg_cnt_ff + 16'h0001);
         end
      end
   end

   // ----------------------------------------
   // response sender
   // ----------------------------------------
   // flow codes go ahead of answer bytes and ignore the pause
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         {tx_valid_ff, tx_ff, xoff_sent_ff, resp_ff, rlen_ff, idx_ff} <= '0;
      end
      else
      begin
         if (exec)
         begin
            resp_ff <= resp_vec;
            rlen_ff <= resp_len;
            idx_ff <= 3'h0;
         end
         else if (issue)
            idx_ff <= 3'(idx_ff + 3'h1);
         if (tx_load)
            tx_valid_ff <= flow_pend | issue;
         if (tx_load && flow_pend)
         begin
            tx_ff <= '{data: want_off ? `RMI_CH_DC3 : `RMI_CH_DC1, eoi: 1'b0};
            xoff_sent_ff <= want_off;
         end
         else if (issue)
            tx_ff <= '{data: cur_b, eoi: last_b & ~serial};
      end
   end

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   wire hit = (paddr_in == `RMI_OFF_CTRL) | (paddr_in == `RMI_OFF_SERCFG) |
              (paddr_in == `RMI_OFF_STATUS);
   wire [31:0] rd_ctrl = (32'(ctrl_ff.gpib_addr) << `RMI_CTRL_ADDR_LSB) |
                         (32'(ctrl_ff.term_sel) << `RMI_CTRL_TERM_LSB) |
                         (32'(ctrl_ff.ack_sup) << `RMI_CTRL_ACKSUP_BIT) |
                         (32'(ctrl_ff.serial_sel) << `RMI_CTRL_SERIAL_BIT);
   wire [31:0] rd_stat = {msg_cnt_ff, 9'h000, xoff_sent_ff, paused_ff, holdoff_ff,
                          last_q_ff, last_err_ff, state_ff};
   wire [31:0] rd_mux = (paddr_in == `RMI_OFF_CTRL) ? rd_ctrl :
                        (paddr_in == `RMI_OFF_SERCFG) ? {11'h000, sercfg_ff} :
                        (paddr_in == `RMI_OFF_STATUS) ? rd_stat : 32'h0000_0000;
   // read data is captured in the setup cycle
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         prdata_ff <= 32'h0000_0000;
      else if (psel_in && !penable_in)
         prdata_ff <= rd_mux;
   end
   assign prdata_out = prdata_ff;
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in & penable_in & ~hit;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_PAUSE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      take && is_dc3 |=> paused_ff && !issue)
      else $error("pause code not honoured");
   AST_RESUME: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      take && is_dc1 |=> !paused_ff)
      else $error("resume code not honoured");
   AST_QUERY: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      exec && query_ff && !err |=> send ##1 tx_valid_ff [*1])
      else $error("query gave no answer");
   AST_NOCHANGE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      exec && err && !wr_ctrl |=> $stable(ctrl_ff))
      else $error("rejected message changed a setting");
   AST_HOLD: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      msg_end && at_new == 2'h2 |=> holdoff_ff throughout exec [*1])
      else $error("hold-off not raised");
   AST_ACK: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      exec && ack_en && !query_ff |=> send &&
      rlen_ff == 3'(($past(err) ? 3'h5 : 3'h2) + $past(term_len)))
      else $error("acknowledgment missing");
   AST_SILENT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      exec && !serial && !query_ff |=> state_ff == rmi_pkg::ST_PARSE)
      else $error("setting answered on gpib");
   AST_EOI: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      tx_valid_ff && $past(serial) && serial |-> !tx_ff.eoi)
      else $error("eoi sent on serial link");
   AST_ADDR: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      take && !serial && !addr_ok && !exec |=> $stable(hlen_ff) && $stable(in_data_ff))
      else $error("foreign address byte parsed");
endmodule : rmi_msg_if

/* logic/rmi_pkg.sv */
// rmi_pkg: types of the remote message interface
package rmi_pkg;
   // parser sequence
   typedef enum logic [1:0] {ST_PARSE, ST_EXEC, ST_SEND} rmi_state_type;
   // control register contents
   typedef struct packed {
      logic [4:0] gpib_addr;
      logic [1:0] term_sel;
      logic ack_sup;
      logic serial_sel;
   } rmi_ctrl_type;
   // serial line settings
   typedef struct packed {
      logic stop2;
      logic [1:0] parity;
      logic [1:0] data_len;
      logic [15:0] baud_div;
   } rmi_sercfg_type;
   // received byte with its link qualifiers
   typedef struct packed {
      logic [7:0] data;
      logic eoi;
      logic [4:0] addr;
   } rmi_rx_type;
   // transmitted byte
   typedef struct packed {
      logic [7:0] data;
      logic eoi;
   } rmi_tx_type;
endpackage : rmi_pkg

/* test/rmi_host_model.sv */
// rmi_host_model: remote controller that sends command bytes and collects answers
`timescale 1ns/1ps
module rmi_host_model
(
   input wire logic clk_in,
   input wire logic serial_in,
   input wire logic slow_in,
   output logic rx_valid_out,
   output rmi_pkg::rmi_rx_type rx_out,
   input wire logic rx_ready_in,
   input wire logic tx_valid_in,
   input wire rmi_pkg::rmi_tx_type tx_in,
   output logic tx_ready_out
);
   rmi_pkg::rmi_tx_type got_q[$]; // answer bytes in arrival order
   logic paused_ff = 1'b0; // device asked us to stop sending
   logic tgl_ff = 1'b0; // stall pattern of a slow sink
   initial
   begin
      rx_valid_out = 1'b0;
      rx_out = '0;
   end
   // a slow sink takes a byte only every other cycle
   assign tx_ready_out = !slow_in || tgl_ff;
   // collect answer bytes and obey the device flow codes on the serial link
   always @(posedge clk_in)
   begin
      tgl_ff <= !tgl_ff;
      if (tx_valid_in && tx_ready_out)
      begin
         got_q.push_back(tx_in);
         if (serial_in && tx_in.data == 8'h13) paused_ff <= 1'b1;
         if (serial_in && tx_in.data == 8'h11) paused_ff <= 1'b0;
      end
   end
   // send one byte on the single chosen link, hold it until taken
   task send(input logic [7:0] d, input logic e, input logic [4:0] a);
      @(posedge clk_in);
      // stay quiet while the device has asked for a pause
      while (paused_ff)
         @(posedge clk_in);
      rx_valid_out <= 1'b1;
      rx_out <= '{d, e, a};
      // hold the byte until the device takes it; the bench timeout ends a hang
      do
         @(posedge clk_in);
      while (!rx_ready_in);
      // released lines show the inverse so no stale byte looks valid
      rx_valid_out <= 1'b0;
      rx_out <= rmi_pkg::rmi_rx_type'(~{d, e, a});
   endtask : send
endmodule : rmi_host_model

/* test/tb_top.sv */
// tb_top: self-checking bench of the remote message interface
`timescale 1ns/1ps
`include "rmi_defs.svh"
module tb_top;
   logic sys_clk, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, dev_status = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, er, rx_valid, rx_ready, tx_valid, tx_ready, holdoff, ser;
   logic slow = 1'b0, hold_seen = 1'b0;
   logic [4:0] gaddr;
   rmi_pkg::rmi_rx_type rx;
   rmi_pkg::rmi_tx_type tx;
   rmi_pkg::rmi_sercfg_type sercfg;
   int n_fail = 0, n_tests = 0, cyc = 0;
   rmi_msg_if DUT (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .rx_valid_in(rx_valid), .rx_in(rx), .rx_ready_out(rx_ready), .tx_valid_out(tx_valid),
      .tx_out(tx), .tx_ready_in(tx_ready), .dev_status_in(dev_status), .holdoff_out(holdoff),
      .serial_sel_out(ser), .gpib_addr_out(gaddr), .sercfg_out(sercfg));
   rmi_host_model HOST (.clk_in(sys_clk), .serial_in(ser), .slow_in(slow),
      .rx_valid_out(rx_valid), .rx_out(rx), .rx_ready_in(rx_ready), .tx_valid_in(tx_valid),
      .tx_in(tx), .tx_ready_out(tx_ready));
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // hold-off monitor and hang guard
   always @(posedge sys_clk)
   begin
      if (holdoff === 1'b1) hold_seen <= 1'b1;
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         complete_run;
      end
   end
   // compare and count
   task check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      if (got !== exp) n_fail++;
   endtask : check
   // one apb transfer, result left in rd and er
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do
         @(posedge sys_clk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // send a message, end-or-identify on its last byte when e is set
   task msg(input string s, input logic e, input logic [4:0] a);
      for (int i = 0; i < s.len(); i++)
         HOST.send(s[i], e && (i == s.len() - 1), a);
   endtask : msg
   // wait for the answer, compare bytes and the end flag of the last one
   task chk_tx(input string s, input logic e);
      int n;
      rmi_pkg::rmi_tx_type b;
      n = 0;
      while (HOST.got_q.size() < s.len() && n < 400)
      begin
         n++;
         @(posedge sys_clk);
      end
      repeat (6) @(posedge sys_clk);
      check(32'(HOST.got_q.size()), 32'(s.len()));
      for (int i = 0; i < s.len(); i++)
      begin
         b = (HOST.got_q.size() > 0) ? HOST.got_q.pop_front() : '1;
         check({23'h0, b}, {23'h0, s[i], e && (i == s.len() - 1)});
      end
      HOST.got_q.delete();
   endtask : chk_tx
   // reset values, field access, unmapped place
   task s_regs;
      apb(1'b0, `RMI_OFF_CTRL, 32'h0000_0000);
      check(rd, 32'h0000_0102);
      apb(1'b0, `RMI_OFF_SERCFG, 32'h0000_0000);
      check(rd, 32'h0003_0001);
      apb(1'b1, `RMI_OFF_SERCFG, 32'h001F_FFFF);
      apb(1'b0, `RMI_OFF_SERCFG, 32'h0000_0000);
      check(rd, {11'h000, sercfg});
      check(rd, 32'h001F_FFFF);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      check({rd[30:0], er}, 32'h0000_0001);
      apb(1'b1, `RMI_OFF_CTRL, 32'h0000_0502);
      // the new address shows from the edge the write lands; it is checked one edge later
      @(posedge sys_clk);
      check({27'h0, gaddr}, 32'h0000_0005);
   endtask : s_regs
   // gpib addressing, queries and default terminator
   task s_gpib;
      dev_status <= 8'h0C;
      slow <= 1'b1;
      msg("SIL 0\n", 1'b1, 5'h01);
      chk_tx("", 1'b0);
      msg("DSR?\n", 1'b1, 5'h05);
      chk_tx("12\r\n", 1'b1);
      slow <= 1'b0;
      msg("SIL?\n", 1'b1, 5'h05);
      chk_tx("1\r\n", 1'b1);
   endtask : s_gpib
   // chaining, hex data, items, answer terminators 0, 1 and 3
   task s_syntax;
      msg("\124RM 1;\124RM?\n", 1'b1, 5'h05);
      chk_tx("1\n", 1'b1);
      msg("\124RM #H3;\124RM?\n", 1'b1, 5'h05);
      chk_tx("3\r", 1'b1);
      // a second item is refused for a one-value setting, so 3 stays
      msg("\124RM 2,1;\124RM?", 1'b1, 5'h05);
      chk_tx("3\r", 1'b1);
      msg("\124RM 0\r", 1'b1, 5'h05);
      chk_tx("", 1'b0);
      msg("\124RM?\n", 1'b0, 5'h05);
      chk_tx("0\r\n", 1'b1);
   endtask : s_syntax
   // hold-off marker
   task s_hold(input string s, input logic exp);
      hold_seen = 1'b0;
      msg(s, 1'b1, 5'h05);
      chk_tx("", 1'b0);
      check({31'h0, hold_seen}, {31'h0, exp});
   endtask : s_hold
   // serial link: acknowledgments, errors and flow codes
   task s_serial;
      apb(1'b1, `RMI_OFF_CTRL, 32'h0000_0101);
      msg("XYZ 1\n", 1'b1, 5'h05);
      chk_tx("\023ERROR\r\n\021", 1'b0);
      msg("SIL 0\n", 1'b1, 5'h05);
      chk_tx("\023OK\r\n\021", 1'b0);
      msg("SIL?\n", 1'b1, 5'h05);
      chk_tx("\0230\r\n\021", 1'b0);
      apb(1'b0, `RMI_OFF_CTRL, 32'h0000_0000);
      check(rd, 32'h0000_0101);
      msg("\023", 1'b0, 5'h05);
      apb(1'b0, `RMI_OFF_STATUS, 32'h0000_0000);
      check({31'h0, rd[5]}, 32'h0000_0001);
      msg("\021", 1'b0, 5'h05);
      apb(1'b0, `RMI_OFF_STATUS, 32'h0000_0000);
      check({31'h0, rd[5]}, 32'h0000_0000);
   endtask : s_serial
   // verdict and end of run
   task complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   initial
   begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      s_regs;
      s_gpib;
      s_syntax;
      s_hold("SIL 1@\n", 1'b1);
      s_hold("SIL 1@", 1'b0);
      s_hold("SIL 1@@", 1'b1);
      s_serial;
      complete_run;
   end
endmodule : tb_top
